// ---- dv/hkr_bank_props.sv ----
// Concurrent checks on the ports of the housekeeping readout bank.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module hkr_bank_props
    import hkr_pkg::*;
#(
    parameter logic [2:0] VERSION = VER_DEF  // Version field to expect
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // Link transaction
    input wire logic              txn_valid,
    input wire logic              txn_write,
    input wire logic [ADDR_W-1:0] txn_addr,
    input wire logic [DATA_W-1:0] txn_wdata,
    // Read answer
    input wire logic              rd_valid,
    input wire logic [DATA_W-1:0] rd_data,
    // Sampled levels
    input wire logic [7:0]        hv_neg_sample,
    input wire logic [7:0]        hv_pos_sample,
    input wire logic [15:0]       reference_sample,
    input wire logic              link_b_active,
    input wire logic              sweep_busy,
    input wire logic [2:0]        mux_select,
    input wire logic              high_voltage_supply_en,
    input wire logic              ac_gain_high,
    input wire logic [2:0]        probe_out_en
);
    // Single domain, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Read of one address, and any write
    sequence s_rd(a);
        txn_valid && !txn_write && txn_addr == a;
    endsequence
    sequence s_wr;
        txn_valid && txn_write;
    endsequence

    a_read_answer: assert property (
        txn_valid && !txn_write |=> rd_valid)
        else $error("read not answered next cycle");
    a_answer_cause: assert property (
        rd_valid |-> $past(txn_valid && !txn_write))
        else $error("answer without a read");
    a_hv_pair: assert property (
        s_rd(ADDR_HV) |=>
        rd_data == {$past(hv_neg_sample), $past(hv_pos_sample)})
        else $error("high voltage word wrong");
    a_ref_word: assert property (
        s_rd(ADDR_REF) |=> rd_data == $past(reference_sample))
        else $error("reference word wrong");
    a_mode_fields: assert property (
        s_rd(ADDR_MODE) |=> rd_data[15:7] == {VERSION,
        $past(link_b_active), $past(sweep_busy), $past(mux_select),
        $past(high_voltage_supply_en)})
        else $error("mode upper fields wrong");
    a_mode_enables: assert property (
        s_rd(ADDR_MODE) |=> rd_data[6:4] == $past(probe_out_en))
        else $error("mode enables wrong");
    a_status_top: assert property (
        s_rd(ADDR_STATUS) |=> rd_data[15:12] == {$past(ac_gain_high), 3'h0})
        else $error("status top bits wrong");
    a_echo_chain: assert property (
        s_wr ##1 s_rd(ADDR_ECHO) |=> rd_data == $past(txn_wdata, 2))
        else $error("echo misses the last write");
    a_data_hold: assert property (
        !(txn_valid && !txn_write) |=> $stable(rd_data))
        else $error("answer changed without a read");
    a_reset_quiet: assert property (
        disable iff (1'b0) !rst_n |-> probe_out_en == 3'h0 && !rd_valid)
        else $error("outputs active in reset");
endmodule // hkr_bank_props

bind hkr_bank hkr_bank_props #(.VERSION(VERSION)) u_props (
    .clk, .rst_n, .txn_valid, .txn_write, .txn_addr, .txn_wdata,
    .rd_valid, .rd_data, .hv_neg_sample, .hv_pos_sample,
    .reference_sample, .link_b_active, .sweep_busy, .mux_select,
    .high_voltage_supply_en, .ac_gain_high, .probe_out_en
);

// ---- dv/hkr_dpu_model.sv ----
// Model of the data processing unit that issues link transactions.
// Assumes the bank answers a read in the cycle after the taking edge.
`timescale 1ns/1ps
module hkr_dpu_model
    import hkr_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Answer from the bank
    input  wire logic              rd_valid,
    input  wire logic [DATA_W-1:0] rd_data,
    // Transaction to the bank
    output logic                   txn_valid,
    output logic                   txn_write,
    output logic      [ADDR_W-1:0] txn_addr,
    output logic      [DATA_W-1:0] txn_wdata
);
    // Quiet link at time zero
    initial begin
        txn_valid = 1'b0;
        txn_write = 1'b0;
        txn_addr  = '0;
        txn_wdata = '0;
    end

    // One transaction, entered just after a rising edge; valid stays
    // up so that calls chain back to back
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic ok,
                        output logic [DATA_W-1:0] q);
        txn_valid = 1'b1;
        txn_write = w;
        txn_addr  = a;
        txn_wdata = d;
        @(posedge clk);
        #1;
        ok = w ? !rd_valid : rd_valid;
        q  = rd_data;
    endtask

    // Released lines change every cycle so no stale value survives
    task automatic idle(input int n);
        txn_valid = 1'b0;
        repeat (n) begin
            txn_addr  = ~txn_addr;
            txn_wdata = ~txn_wdata;
            @(posedge clk);
            #1;
        end
    endtask
endmodule // hkr_dpu_model

// ---- dv/test_housekeeping_readout_map.sv ----
// Self-checking bench for the housekeeping readout bank.
// Assumes the link model and the bound checker are compiled with it.
`timescale 1ns/1ps
module test_housekeeping_readout_map
    import hkr_pkg::*;
;
    localparam logic [2:0] VER_SET = 3'h5;  // Arbitrary version value

    // Design ports
    logic clk, rst_n, txn_valid, txn_write, rd_valid;
    logic [5:0] txn_addr, sweep_wr_index;
    logic [15:0] txn_wdata, rd_data, reference_sample, sweep_wr_data;
    logic [7:0] hv_neg_sample, hv_pos_sample;
    logic link_b_active, sweep_busy, high_voltage_supply_en, ac_gain_high;
    logic diff_pair_one_three, bypass_probe_three, bypass_probe_one;
    logic [2:0] mux_select, probe_enable_cmd, probe_out_en;
    logic sweep_wr_valid, sweep_wr_ready;
    logic [1:0] sweep_wr_probe;
    // Bench bookkeeping: expected counter, page and echo
    int n_fail, cmp_count;
    logic [3:0] wcount;
    logic [7:0] page;
    logic [15:0] echo;
    logic [2:0] v;

    hkr_bank #(.VERSION(VER_SET)) DUT (
        .clk, .rst_n, .txn_valid, .txn_write, .txn_addr, .txn_wdata,
        .rd_valid, .rd_data, .hv_neg_sample, .hv_pos_sample,
        .reference_sample, .link_b_active, .sweep_busy, .mux_select,
        .high_voltage_supply_en, .probe_enable_cmd, .diff_pair_one_three,
        .bypass_probe_three, .bypass_probe_one, .ac_gain_high,
        .sweep_wr_valid, .sweep_wr_probe, .sweep_wr_index, .sweep_wr_data,
        .sweep_wr_ready, .probe_out_en
    );
    hkr_dpu_model u_dpu (
        .clk, .rd_valid, .rd_data, .txn_valid, .txn_write, .txn_addr,
        .txn_wdata
    );

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        logic ok;
        logic [15:0] q;
        u_dpu.xfer(1'b0, a, 16'h0000, ok, q);
        chk({15'h0, ok}, 16'h0001);
        chk(q, exp);
    endtask

    // Link write; the bench tracks what the status word must show
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic ok;
        logic [15:0] q;
        u_dpu.xfer(1'b1, a, d, ok, q);
        chk({15'h0, ok}, 16'h0001);
        wcount = wcount + 4'h1;  // Wraps like the design's counter
        echo   = d;
        if (a == ADDR_PAGE_SEL) page = d[7:0];
    endtask

    // Sweep result write; valid stays up for back-to-back use
    task automatic sw(input int p, input logic [5:0] i);
        sweep_wr_valid = 1'b1;
        sweep_wr_probe = 2'(p);
        sweep_wr_index = i;
        sweep_wr_data  = 16'(4096 * p) | {10'h0, i};
        #1;
        chk({15'h0, sweep_wr_ready}, 16'h0001);
        @(posedge clk);
        #1;
    endtask

    task automatic finish_test;
        if (n_fail == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog against a hung sequence
    initial begin
        #200000;
        n_fail++;
        finish_test;
    end

    initial begin
        n_fail = 0;
        cmp_count = 0;
        {wcount, page, echo} = '0;
        rst_n = 1'b0;
        {hv_neg_sample, hv_pos_sample} = 16'hA53C;
        reference_sample = 16'h8123;
        {link_b_active, sweep_busy, high_voltage_supply_en} = 3'h0;
        {ac_gain_high, diff_pair_one_three} = 2'h0;
        {bypass_probe_three, bypass_probe_one} = 2'h0;
        mux_select = 3'h0;
        probe_enable_cmd = 3'h7;  // Must not reach the outputs in reset
        {sweep_wr_valid, sweep_wr_probe, sweep_wr_index} = '0;
        sweep_wr_data = 16'h0000;
        repeat (12) @(posedge clk);
        #1;
        chk({13'h0, probe_out_en}, 16'h0000);
        rst_n = 1'b1;
        @(posedge clk);
        #1;
        // Fresh state, samples, unmapped places
        rd(ADDR_STATUS, 16'h0000);
        rd(ADDR_ECHO, 16'h0000);
        rd(ADDR_HV, 16'hA53C);
        rd(ADDR_REF, 16'h8123);
        rd(6'h0A, 16'h0000);
        rd(6'h2A, 16'h0000);
        // Every mode field but the fixed version through all eight patterns
        for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            {link_b_active, sweep_busy} = v[1:0];
            high_voltage_supply_en = v[2];
            mux_select = v;
            probe_enable_cmd = ~v;
            {diff_pair_one_three, bypass_probe_three} = {v[0], v[2]};
            bypass_probe_one = v[1];
            u_dpu.idle(1);
            chk({13'h0, probe_out_en}, {13'h0, ~v});
            rd(ADDR_MODE, {VER_SET, v[1:0], v, v[2], ~v, v[0], v[2],
               v[1], 1'b0});
        end
        // Counter through its wrap, echo and page after each write
        ac_gain_high = 1'b1;
        for (int k = 0; k < 17; k++) begin
            wr(ADDR_PAGE_SEL, 16'h5A00 | 16'(k));
            rd(ADDR_ECHO, echo);
            rd(ADDR_STATUS, {4'h8, wcount, page});
        end
        rd(ADDR_STATUS, {4'h8, wcount, page});
        // Both end indices of each probe region, then read back
        for (int p = 1; p < 4; p++)
            for (int j = 0; j < 2; j++)
                sw(p, j ? 6'h3F : 6'h00);
        sweep_wr_valid = 1'b0;
        sweep_wr_data  = ~sweep_wr_data;
        sweep_wr_probe = 2'h0;
        u_dpu.idle(3);
        chk({15'h0, sweep_wr_ready}, 16'h0000);
        for (int p = 1; p < 4; p++)
            for (int j = 0; j < 2; j++) begin
                wr(ADDR_PAGE_SEL, 16'(4 * p + 3 * j));
                rd(6'h10 + 6'(15 * j),
                   16'(4096 * p + 63 * j));
            end
        // Table load only on pages 4 to 7
        wr(ADDR_PAGE_SEL, 16'h0005);
        wr(6'h37, 16'hBEEF);
        rd(6'h17, 16'hBEEF);
        wr(ADDR_PAGE_SEL, 16'h0008);
        wr(6'h30, 16'hDEAD);
        rd(6'h10, 16'h2000);
        rd(ADDR_STATUS, {4'h8, wcount, page});
        // Hard reset in mid-run clears state and output enables
        probe_enable_cmd = 3'h5;
        rst_n = 1'b0;
        u_dpu.idle(3);
        chk({13'h0, probe_out_en}, 16'h0000);
        rst_n = 1'b1;
        u_dpu.idle(1);
        rd(ADDR_STATUS, 16'h8000);
        rd(ADDR_ECHO, 16'h0000);
        finish_test;
    end
endmodule // test_housekeeping_readout_map

// ---- inc/hkr_pkg.sv ----
// Constants and types for the housekeeping readout bank.
// Assumes a 6-bit link address, 16-bit data words and one 100 MHz clock.
package hkr_pkg;

    // Link geometry
    localparam int ADDR_W   = 6;   // Link address width
    localparam int DATA_W   = 16;  // Link data width
    localparam int PAGE_W   = 8;   // Page register width
    localparam int WSEL_W   = 4;   // Word select inside a page
    localparam int CNT_W    = 4;   // Write counter width
    localparam int MADDR_W  = PAGE_W + WSEL_W;  // Paged memory address

    // Read map
    localparam logic [5:0] ADDR_HV      = 6'h0B;  // High-voltage samples
    localparam logic [5:0] ADDR_REF     = 6'h0C;  // Reference sample
    localparam logic [5:0] ADDR_MODE    = 6'h0D;  // Mode word
    localparam logic [5:0] ADDR_STATUS  = 6'h0E;  // Status word
    localparam logic [5:0] ADDR_ECHO    = 6'h0F;  // Last write echo
    localparam logic [1:0] PAGED_TOP    = 2'h1;   // A5:4 of 0x10-0x1F

    // Write map
    localparam logic [5:0] ADDR_PAGE_SEL = 6'h20; // Page select command
    localparam logic [1:0] SWEEP_TOP     = 2'h3;  // A5:4 of 0x30-0x3F
    localparam logic [7:0] SWEEP_PG_LO   = 8'h04; // First sweep table page
    localparam logic [7:0] SWEEP_PG_HI   = 8'h07; // Last sweep table page

    // Sweep result regions in paged memory, 64 words each
    localparam logic [11:0] PROBE1_BASE = 12'h040;  // Words 64-127
    localparam logic [11:0] PROBE2_BASE = 12'h080;  // Words 128-191
    localparam logic [11:0] PROBE3_BASE = 12'h0C0;  // Words 192-255

    // Mode word field positions
    localparam int MODE_VER_LSB  = 13;
    localparam int MODE_LINK_BIT = 12;
    localparam int MODE_SWP_BIT  = 11;
    localparam int MODE_MUX_LSB  = 8;
    localparam int MODE_HV_BIT   = 7;
    localparam int MODE_EN3_BIT  = 6;
    localparam int MODE_EN2_BIT  = 5;
    localparam int MODE_EN1_BIT  = 4;
    localparam int MODE_DIFF_BIT = 3;
    localparam int MODE_BYP3_BIT = 2;
    localparam int MODE_BYP1_BIT = 1;

    // Status word field positions
    localparam int STAT_GAIN_BIT = 15;
    localparam int STAT_CNT_LSB  = 8;
    localparam int STAT_PAGE_LSB = 0;

    // Reset values
    localparam logic [7:0]  PAGE_RST = 8'h00;
    localparam logic [3:0]  CNT_RST  = 4'h0;
    localparam logic [15:0] ECHO_RST = 16'h0000;
    localparam logic [15:0] RDAT_RST = 16'h0000;
    localparam logic [2:0]  VER_DEF  = 3'h1;  // Arbitrary version value

    // Source selected for a read answer
    typedef enum logic [2:0] {
        SRC_NONE   = 3'b000,
        SRC_HV     = 3'b001,
        SRC_REF    = 3'b010,
        SRC_MODE   = 3'b011,
        SRC_STATUS = 3'b100,
        SRC_ECHO   = 3'b101,
        SRC_PAGED  = 3'b110
    } hkr_src_t;

endpackage

// ---- src/hkr_bank.sv ----
// Housekeeping readout bank: answers link reads, tracks link writes,
// loads the sweep table and keeps the paged diagnostic memory.
// Assumes the serial link is already decoded into a one-cycle
// transaction strobe synchronous to clk, and that the analogue samples
// and control levels come from logic on the same clock.
//
// Behaviour
// (R01) Read flag 0, 6-bit address, 16-bit answer
// (R02) 0x0B: negative HV high, positive HV low
// (R03) 0x0C: 16-bit reference voltage sample
// (R04) Mode bits 15:13 hold design version
// (R05) Mode bit 12 link, bit 11 sweep busy
// (R06) Mode bits 10:8 give multiplexer selection
// (R07) Mode bit 7 shows HV supplies enabled
// (R08) Mode bits 6:4 show probe three..one enables
// (R09) Mode bit 3 picks differential probe pair
// (R10) Mode bits 2,1 bypass probe three, one
// (R11) Status bit 15 shows AC gain
// (R12) Status bits 11:8 count link writes
// (R13) Status bits 7:0 show current page
// (R14) 0x0F returns data of last write
// (R15) 0x10-0x1F read page word by low bits
// (R16) Probe one results at words 64-127
// (R17) Probe two results at words 128-191
// (R18) Probe three results at words 192-255
// (R19) Hard reset only; no probe output driven
// (R20) Write flag 1; pages 4-7 load table
// (R21) Write counter wraps; status 14:12 zero
// (R22) Reads have no side effects
//
// Paged memory is never reset;
// unwritten words read unknown.

`timescale 1ns/1ps
module hkr_bank
    import hkr_pkg::*;
#(
    parameter logic [2:0] VERSION = VER_DEF  // Arbitrary version value
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Decoded link transaction
    input  wire logic              txn_valid,
    input  wire logic              txn_write,
    input  wire logic [ADDR_W-1:0] txn_addr,
    input  wire logic [DATA_W-1:0] txn_wdata,
    // Read answer
    output logic                   rd_valid,
    output logic      [DATA_W-1:0] rd_data,
    // Analogue samples, offset binary
    input  wire logic [7:0]        hv_neg_sample,
    input  wire logic [7:0]        hv_pos_sample,
    input  wire logic [15:0]       reference_sample,
    // Control levels reported in the mode word; AC gain goes to the status word
    input  wire logic              link_b_active,
    input  wire logic              sweep_busy,
    input  wire logic [2:0]        mux_select,
    input  wire logic              high_voltage_supply_en,
    input  wire logic [2:0]        probe_enable_cmd,
    input  wire logic              diff_pair_one_three,
    input  wire logic              bypass_probe_three,
    input  wire logic              bypass_probe_one,
    input  wire logic              ac_gain_high,
    // Sweep result write port
    input  wire logic              sweep_wr_valid,
    input  wire logic [1:0]        sweep_wr_probe,
    input  wire logic [5:0]        sweep_wr_index,
    input  wire logic [DATA_W-1:0] sweep_wr_data,
    output logic                   sweep_wr_ready,
    // Probe channel output enables
    output logic      [2:0]        probe_out_en
);

    // Decoded strobes of the current transaction
    // All are combinational
    logic               rd_stb;      // Read taken this cycle
    logic               wr_stb;      // Write taken this cycle
    logic               table_wr;    // Write that loads the sweep table
    hkr_src_t           rd_src;      // Source of the read answer

    // State held by the write tracker
    // Only writes and a hard
    // reset change it
    logic [CNT_W-1:0]   wr_count;
    logic [DATA_W-1:0]  last_word;
    logic [PAGE_W-1:0]  page;

    // Paged memory ports
    // Link and sweep engine
    // share one write port
    logic               mem_we;
    logic [MADDR_W-1:0] mem_waddr;
    logic [DATA_W-1:0]  mem_wdata;
    logic [MADDR_W-1:0] mem_raddr;
    logic [DATA_W-1:0]  mem_rdata;
    logic [MADDR_W-1:0] sweep_addr;  // Result word address from probe

    // Assembled words
    // Rebuilt from live inputs and
    // held registers on every cycle
    logic [DATA_W-1:0]  mode_word;
    logic [DATA_W-1:0]  status_word;
    logic [DATA_W-1:0]  rd_data_next;

    // Registered outputs
    // Far side sees no decode
    // glitches on them
    logic               rd_valid_reg;
    logic [DATA_W-1:0]  rd_data_reg;
    logic [2:0]         probe_en_reg;

    // Maps a read address onto its answer source
    // Exact matches first, then the
    // paged window; rest unmapped
    function automatic hkr_src_t decode_src(input logic [ADDR_W-1:0] a);
        if (a == ADDR_HV) begin
            decode_src = SRC_HV;
        end else if (a == ADDR_REF) begin
            decode_src = SRC_REF;
        end else if (a == ADDR_MODE) begin
            decode_src = SRC_MODE;
        end else if (a == ADDR_STATUS) begin
            decode_src = SRC_STATUS;
        end else if (a == ADDR_ECHO) begin
            decode_src = SRC_ECHO;
        end else if (a[5:4] == PAGED_TOP) begin
            decode_src = SRC_PAGED;
        end else begin
            decode_src = SRC_NONE;
        end
    endfunction

    // Base word of the result region for a probe number 1..3
    // Probe 0 falls back to one;
    // ready refuses it anyway
    function automatic logic [MADDR_W-1:0] probe_base(input logic [1:0] p);
        case (p)
            2'h1:    probe_base = PROBE1_BASE;  // R16
            2'h2:    probe_base = PROBE2_BASE;  // R17
            2'h3:    probe_base = PROBE3_BASE;  // R18
            default: probe_base = PROBE1_BASE;
        endcase
    endfunction

    // Direction flag splits each transaction into read or write
    // Each strobe lasts one cycle
    assign rd_stb = txn_valid && !txn_write;  // R01
    assign wr_stb = txn_valid && txn_write;   // R20
    assign rd_src = decode_src(txn_addr);

    // Sweep table loads only on pages 4-7 at addresses 0x30-0x3F;
    // other pages are refused; pages 4-7 hold probe one results (words 64-127), which a table load overwrites
    // A refused write still counts
    // and is still echoed
    assign table_wr = wr_stb && txn_addr[5:4] == SWEEP_TOP
                      && page >= SWEEP_PG_LO
                      && page <= SWEEP_PG_HI;  // R20

    // Write tracking: counter, echo and page register
    // Every write counts, mapped or not
    hkr_cmd_track u_track (
        .clk       (clk),
        .rst_n     (rst_n),
        .wr_stb    (wr_stb),
        .wr_addr   (txn_addr),
        .wr_data   (txn_wdata),
        .wr_count  (wr_count),
        .last_word (last_word),
        .page      (page)
    );

    // Result word address: region base plus sample index
    // A 6-bit index cannot spill
    // into the next region
    assign sweep_addr = probe_base(sweep_wr_probe)
                        + {6'h00, sweep_wr_index};

    // Link table writes take the memory first; the sweep engine stalls
    // for that cycle, which costs it at most one cycle per link write.
    // A probe number of 0 is not a result region and is never accepted.
    // Ready ignores valid, so no
    // combinational loop forms
    assign sweep_wr_ready = !table_wr && sweep_wr_probe != 2'h0;

    // Memory write port arbitration
    // One writer per cycle; the
    // link wins, the engine waits
    always_comb begin
        if (table_wr) begin
            mem_we    = 1'b1;
            mem_waddr = {page, txn_addr[WSEL_W-1:0]};  // R20
            mem_wdata = txn_wdata;
        end else begin
            mem_we    = sweep_wr_valid && sweep_wr_ready;
            mem_waddr = sweep_addr;  // R16 R17 R18
            mem_wdata = sweep_wr_data;
        end
    end

    // Page selects the 16-word block, low address bits the word
    // Formed every cycle; only a
    // paged read uses it
    assign mem_raddr = {page, txn_addr[WSEL_W-1:0]};  // R15

    // Paged diagnostic memory
    // Asynchronous read gives paged
    // words the same latency as
    // the register answers
    hkr_page_ram #(
        .AW (MADDR_W),
        .DW (DATA_W)
    ) u_ram (
        .clk     (clk),
        .wr_en   (mem_we),
        .wr_addr (mem_waddr),
        .wr_data (mem_wdata),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata)
    );

    // Mode word from the reported control levels
    // Enables come from the output
    // register: what probes get.
    // Version is fixed at build
    always_comb begin
        mode_word = 16'h0000;
        mode_word[MODE_VER_LSB +: 3] = VERSION;               // R04
        mode_word[MODE_LINK_BIT]     = link_b_active;         // R05
        mode_word[MODE_SWP_BIT]      = sweep_busy;            // R05
        mode_word[MODE_MUX_LSB +: 3] = mux_select;            // R06
        mode_word[MODE_HV_BIT]       = high_voltage_supply_en;  // R07
        mode_word[MODE_EN3_BIT]      = probe_en_reg[2];       // R08
        mode_word[MODE_EN2_BIT]      = probe_en_reg[1];       // R08
        mode_word[MODE_EN1_BIT]      = probe_en_reg[0];       // R08
        mode_word[MODE_DIFF_BIT]     = diff_pair_one_three;   // R09
        mode_word[MODE_BYP3_BIT]     = bypass_probe_three;    // R10
        mode_word[MODE_BYP1_BIT]     = bypass_probe_one;      // R10
    end

    // Status word; bits 14:12 stay zero
    // Gain is a raw level
    always_comb begin
        status_word = 16'h0000;                                // R21
        status_word[STAT_GAIN_BIT]         = ac_gain_high;     // R11
        status_word[STAT_CNT_LSB +: CNT_W] = wr_count;         // R12
        status_word[STAT_PAGE_LSB +: PAGE_W] = page;           // R13
    end

    // Answer multiplexer; unmapped reads answer zero
    // The link has no error reply
    always_comb begin
        case (rd_src)
            SRC_HV:     rd_data_next = {hv_neg_sample,
                                        hv_pos_sample};  // R02
            SRC_REF:    rd_data_next = reference_sample;  // R03
            SRC_MODE:   rd_data_next = mode_word;
            SRC_STATUS: rd_data_next = status_word;
            SRC_ECHO:   rd_data_next = last_word;         // R14
            SRC_PAGED:  rd_data_next = mem_rdata;         // R15
            default:    rd_data_next = 16'h0000;
        endcase
    end

    // Answer strobe one cycle after the read is taken
    // Writes never raise it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_stb;  // R01
        end
    end

    // Answer data holds until the next read; a read loads only this
    // register and the answer strobe, and changes no other state
    // Zero in reset: the answer shows
    // a clean word before the first read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= RDAT_RST;
        end else if (rd_stb) begin
            rd_data_reg <= rd_data_next;  // R22
        end
    end

    // Probe drivers follow the command enables; reset forces all off,
    // so a hard reset always leaves the antennas undriven
    // One cycle of delay buys a
    // glitch-free enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            probe_en_reg <= 3'h0;  // R19
        end else begin
            probe_en_reg <= probe_enable_cmd;
        end
    end

    // Outputs straight from registers
    assign rd_valid     = rd_valid_reg;
    assign rd_data      = rd_data_reg;
    assign probe_out_en = probe_en_reg;

endmodule // hkr_bank

// ---- src/hkr_cmd_track.sv ----
// Tracks link writes: write counter, last written word and current page.
// Assumes a one-cycle write strobe with address and data valid alongside.
`timescale 1ns/1ps
module hkr_cmd_track
    import hkr_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Write strobe from the link
    input  wire logic              wr_stb,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    // Tracked state
    output logic      [CNT_W-1:0]  wr_count,
    output logic      [DATA_W-1:0] last_word,
    output logic      [PAGE_W-1:0] page
);

    logic [CNT_W-1:0]  cnt_reg;   // Writes seen, modulo 16
    logic [DATA_W-1:0] echo_reg;  // Data of the newest write
    logic [PAGE_W-1:0] page_reg;  // Page used by paged accesses

    // Counter wraps freely; reads never touch it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= CNT_RST;
        end else if (wr_stb) begin
            cnt_reg <= cnt_reg + 4'h1;  // R12 R21
        end
    end

    // Every write is echoed, whatever its address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            echo_reg <= ECHO_RST;
        end else if (wr_stb) begin
            echo_reg <= wr_data;  // R14
        end
    end

    // Page select command takes the low byte of the data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            page_reg <= PAGE_RST;
        end else if (wr_stb && wr_addr == ADDR_PAGE_SEL) begin
            page_reg <= wr_data[PAGE_W-1:0];  // R13
        end
    end

    assign wr_count  = cnt_reg;
    assign last_word = echo_reg;
    assign page      = page_reg;

endmodule // hkr_cmd_track

// ---- src/hkr_page_ram.sv ----
// Paged diagnostic memory with one write port and one asynchronous read.
// Assumes writes are arbitrated upstream; one write per clock at most.
`timescale 1ns/1ps
module hkr_page_ram
    import hkr_pkg::*;
#(
    parameter int AW = MADDR_W,  // Word address width
    parameter int DW = DATA_W    // Word width
) (
    // Clock
    input  wire logic          clk,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // Read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    // Storage: content is undefined after power-up, as in real RAM
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Single write port; no reset so it maps onto block RAM
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Combinational read keeps the answer at one cycle
    assign rd_data = mem[rd_addr];

endmodule // hkr_page_ram
